//--- shared/cfdr_defines.vh
// constants of the counter/frequency extended diagnostic record block
`ifndef CFDR_DEFINES_VH
`define CFDR_DEFINES_VH

// apb byte offsets, one aligned word per register
`define CFDR_OFF_REC0       8'h00
`define CFDR_OFF_REC1       8'h04
`define CFDR_OFF_REC2       8'h08
`define CFDR_OFF_REC3       8'h0c
`define CFDR_OFF_CTRL       8'h10
`define CFDR_OFF_DSTAT      8'h14
`define CFDR_OFF_DCLR       8'h18
`define CFDR_OFF_DEN        8'h1c
`define CFDR_OFF_PPEND      8'h20
`define CFDR_OFF_PACK       8'h24

// fixed header contents
`define CFDR_CH_TYPE        7'h76
`define CFDR_BITS_PER_CH    8'h08
`define CFDR_NUM_CH         8'h04

// control register fields and reset value
`define CFDR_CTRL_W         2
`define CFDR_CTRL_MODE      0
`define CFDR_CTRL_MORE      1
`define CFDR_CTRL_RST       2'h0
`define CFDR_MODE_CNT       1'b0
`define CFDR_MODE_FRQ       1'b1

// byte width and lowest bit of record byte 11 inside the lost-flag word
`define CFDR_BYTE_W         8
`define CFDR_B11_LSB        24

// bit positions inside record bytes 8..11; gate and latch bits exist in byte 11 only
`define CFDR_B_GOPEN        0
`define CFDR_B_GCLOSE       1
`define CFDR_B_OVF          2
`define CFDR_B_CMP          3
`define CFDR_B_LATCH        4
`define CFDR_B_MEND         0

// bits of the lost-flag word that exist in each mode
`define CFDR_MASK_CNT       32'h1f0c0c0c
`define CFDR_MASK_FRQ       32'h01010101

// channel-group error bits in byte 7
`define CFDR_GRP_W          4

`endif

//--- core/cfdr_sticky.v
// sticky flag vector: set wins over clear in the same cycle
`timescale 1ns/10ps
module cfdr_sticky #(
  parameter W = 32
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [W-1:0] set_i,
  input  wire [W-1:0] clr_i,
  output reg  [W-1:0] flag_q
);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_q <= {W{1'b0}};
    else
      flag_q <= (flag_q & ~clr_i) | set_i;
  end

endmodule // cfdr_sticky

//--- core/cfdr_evt_map.v
// places channel event pulses at their record bit positions for the active mode
`timescale 1ns/10ps
`include "cfdr_defines.vh"
module cfdr_evt_map (
  input  wire        mode,
  input  wire [3:0]  ovf_evt,
  input  wire [3:0]  cmp_evt,
  input  wire        gate_open_evt,
  input  wire        gate_close_evt,
  input  wire        latch_evt,
  input  wire [3:0]  meas_end_evt,
  output reg  [31:0] evt_word
);

  integer i;

  always @*
  begin
    evt_word = 32'h0000_0000;
    for (i = 0; i < 4; i = i + 1)
    begin
      if (mode == `CFDR_MODE_CNT)
      begin
        evt_word[`CFDR_BYTE_W*i + `CFDR_B_OVF] = ovf_evt[i];
        evt_word[`CFDR_BYTE_W*i + `CFDR_B_CMP] = cmp_evt[i];
      end
      else
        evt_word[`CFDR_BYTE_W*i + `CFDR_B_MEND] = meas_end_evt[i];
    end
    if (mode == `CFDR_MODE_CNT)
    begin
      evt_word[`CFDR_B11_LSB + `CFDR_B_GOPEN]  = gate_open_evt;
      evt_word[`CFDR_B11_LSB + `CFDR_B_GCLOSE] = gate_close_evt;
      evt_word[`CFDR_B11_LSB + `CFDR_B_LATCH]  = latch_evt;
    end
  end

endmodule // cfdr_evt_map

//--- core/cfdr_top.v
// extended diagnostic record for counter and frequency channels, apb slave
`timescale 1ns/10ps
`include "cfdr_defines.vh"
// Notes on behaviour
// - record is basic four bytes plus twelve extra bytes, sixteen total
// - bytes 0 to 3 copy the currently reported basic record
// - byte 4 bits 6..0 hold channel type 76h in both modes
// - byte 4 bit 7 is one when further channel types exist
// - byte 5 holds diagnostic bits per channel, constant 08h
// - byte 6 holds the channel count, constant 04h, both modes
// - counting: byte 7 bits 0..3 flag group errors of counters 0..3
// - each lost-interrupt flag in bytes 8..11 raises the diagnostic interrupt when its enable bit is set
// - counting: bit 2 of bytes 8..11 flags lost overflow/underflow/end value
// - counting: bit 3 flags lost comparison interrupt; bytes 8..10 bits 7..4 zero
// - counter 3: byte 11 bits 0 and 1 flag lost gate open and close
// - counter 3: byte 11 bit 4 flags lost latch value; bits 7..5 zero
// - frequency: byte 7 bits 0..3 flag errors of meters 0..3, rest zero
// - frequency: bit 0 of bytes 8..11 flags lost end of measurement
module cfdr_top #(
  parameter ADDR_W = 8
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  input  wire [3:0]        pstrb,
  output wire [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  input  wire [31:0]       basic_rec,
  input  wire [3:0]        grp_err,
  input  wire [3:0]        ovf_evt,
  input  wire [3:0]        cmp_evt,
  input  wire              gate_open_evt,
  input  wire              gate_close_evt,
  input  wire              latch_evt,
  input  wire [3:0]        meas_end_evt,
  output wire              diag_irq,
  output wire              proc_irq
);

  // bus phases
  wire                   setup_ph;
  wire                   access_ph;
  wire                   wr_acc;

  // software-visible state
  reg  [`CFDR_CTRL_W-1:0] ctrl_q;
  reg  [`CFDR_CTRL_W-1:0] ctrl_d;
  reg  [31:0]             den_q;
  reg  [31:0]             den_d;
  reg  [31:0]             basic_q;
  reg  [`CFDR_GRP_W-1:0]  grp_err_q;

  // read path
  reg  [31:0]            rdata_q;
  reg  [31:0]            rdata_d;
  reg                    rerr_q;
  reg                    rerr_d;

  // flag vectors
  wire [31:0]            evt_word;
  wire [31:0]            valid_mask;
  wire [31:0]            pend_q;
  wire [31:0]            lost_q;
  wire [31:0]            pend_set;
  wire [31:0]            pend_clr;
  wire [31:0]            lost_set;
  wire [31:0]            lost_clr;
  wire [31:0]            wmask;
  wire                   mode;

  // record words, byte 0 of each word in bits 7..0
  wire [31:0]            rec_w0;
  wire [31:0]            rec_w1;
  wire [31:0]            rec_w2;
  wire [31:0]            rec_w3;
  wire [7:0]             rec_b4;
  wire [7:0]             rec_b5;
  wire [7:0]             rec_b6;
  wire [7:0]             rec_b7;

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  // zero wait states: every access completes in its first access cycle
  assign pready    = 1'b1;
  assign wr_acc    = access_ph & pwrite & pready;

  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  assign mode = ctrl_q[`CFDR_CTRL_MODE];

  // only the bits defined for the active mode can ever be set
  assign valid_mask = (mode == `CFDR_MODE_CNT) ? `CFDR_MASK_CNT : `CFDR_MASK_FRQ;

  cfdr_evt_map u_evt_map (
    .mode           (mode),
    .ovf_evt        (ovf_evt),
    .cmp_evt        (cmp_evt),
    .gate_open_evt  (gate_open_evt),
    .gate_close_evt (gate_close_evt),
    .latch_evt      (latch_evt),
    .meas_end_evt   (meas_end_evt),
    .evt_word       (evt_word)
  );

  // process interrupt pending per source; acknowledged by software
  assign pend_set = evt_word & valid_mask;
  assign pend_clr = (wr_acc && (paddr == `CFDR_OFF_PACK)) ? (pwdata & wmask) : 32'h0000_0000;

  cfdr_sticky #(
    .W (32)
  ) u_pend (
    .pclk    (pclk),
    .presetn (presetn),
    .set_i   (pend_set),
    .clr_i   (pend_clr),
    .flag_q  (pend_q)
  );

  // a new event while the previous one is still unacknowledged is lost;
  // an acknowledge in the same cycle frees the slot, so that is not a loss
  assign lost_set = pend_set & pend_q & ~pend_clr;
  assign lost_clr = (wr_acc && (paddr == `CFDR_OFF_DCLR)) ? (pwdata & wmask) : 32'h0000_0000;

  cfdr_sticky #(
    .W (32)
  ) u_lost (
    .pclk    (pclk),
    .presetn (presetn),
    .set_i   (lost_set),
    .clr_i   (lost_clr),
    .flag_q  (lost_q)
  );

  // diagnostic interrupt while any enabled lost flag stands
  assign diag_irq = |(lost_q & den_q);
  assign proc_irq = |pend_q;

  // control and enable registers
  always @*
  begin
    ctrl_d = ctrl_q;
    den_d  = den_q;
    if (wr_acc)
    begin
      if (paddr == `CFDR_OFF_CTRL)
      begin
        if (pstrb[0])
          ctrl_d = pwdata[`CFDR_CTRL_W-1:0];
      end
      else if (paddr == `CFDR_OFF_DEN)
      begin
        den_d = (den_q & ~wmask) | (pwdata & wmask);
      end
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `CFDR_CTRL_RST;
      den_q  <= 32'h0000_0000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      den_q  <= den_d;
    end
  end

  // basic record and group errors sampled so the record reads from flops
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      basic_q   <= 32'h0000_0000;
      grp_err_q <= {`CFDR_GRP_W{1'b0}};
    end
    else
    begin
      basic_q   <= basic_rec;
      grp_err_q <= grp_err;
    end
  end

  // record bytes 0..3
  assign rec_w0 = basic_q;

  // header bytes 4..6
  assign rec_b4 = {ctrl_q[`CFDR_CTRL_MORE], `CFDR_CH_TYPE};
  assign rec_b5 = `CFDR_BITS_PER_CH;
  assign rec_b6 = `CFDR_NUM_CH;

  // same four inputs mean counters 0..3 or meters 0..3 by mode
  assign rec_b7 = {4'h0, grp_err_q};

  assign rec_w1 = {rec_b7, rec_b6, rec_b5, rec_b4};

  // masking keeps stale flags of the other mode out of the record
  assign rec_w2 = lost_q & valid_mask;

  // trailing bytes 12..15
  assign rec_w3 = 32'h0000_0000;

  // read mux, if/else decode; unmapped offsets answer with an error
  always @*
  begin
    rdata_d = 32'h0000_0000;
    rerr_d  = 1'b0;
    if (paddr == `CFDR_OFF_REC0)
      rdata_d = rec_w0;
    else if (paddr == `CFDR_OFF_REC1)
      rdata_d = rec_w1;
    else if (paddr == `CFDR_OFF_REC2)
      rdata_d = rec_w2;
    else if (paddr == `CFDR_OFF_REC3)
      rdata_d = rec_w3;
    else if (paddr == `CFDR_OFF_CTRL)
      rdata_d = {{(32-`CFDR_CTRL_W){1'b0}}, ctrl_q};
    else if (paddr == `CFDR_OFF_DSTAT)
      rdata_d = lost_q;
    else if (paddr == `CFDR_OFF_DCLR)
      rdata_d = 32'h0000_0000;
    else if (paddr == `CFDR_OFF_DEN)
      rdata_d = den_q;
    else if (paddr == `CFDR_OFF_PPEND)
      rdata_d = pend_q;
    else if (paddr == `CFDR_OFF_PACK)
      rdata_d = 32'h0000_0000;
    else
      rerr_d = 1'b1;
  end

  // read data captured in the setup cycle, shown in the access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= 32'h0000_0000;
      rerr_q  <= 1'b0;
    end
    else if (setup_ph)
    begin
      rdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
      rerr_q  <= rerr_d;
    end
  end

  assign prdata  = rdata_q;
  assign pslverr = rerr_q & access_ph;

endmodule // cfdr_top

//--- verification/cfdr_asserts.sv
// port-level assertions for the diagnostic record slave
`timescale 1ns/10ps
module cfdr_asserts #(
  parameter ADDR_W = 8
) (
  input wire              pclk,
  input wire              presetn,
  input wire              psel,
  input wire              penable,
  input wire              pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0]       prdata,
  input wire              pslverr,
  input wire [31:0]       basic_rec,
  input wire [3:0]        grp_err,
  input wire              diag_irq,
  input wire              proc_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel & penable;
  wire rd  = acc & ~pwrite;
  // read data is taken at the setup edge, so inputs are two edges old
  property p_rec0; rd && paddr == 8'h00 |-> prdata == $past(basic_rec, 2); endproperty
  a_rec0: assert property (p_rec0) else $error("rec0 bad");
  property p_hdr; rd && paddr == 8'h04 |-> prdata[23:8] == 16'h0408 && prdata[6:0] == 7'h76;
  endproperty
  a_hdr: assert property (p_hdr) else $error("header bad");
  property p_grp; rd && paddr == 8'h04 |-> prdata[31:24] == {4'h0, $past(grp_err, 2)}; endproperty
  a_grp: assert property (p_grp) else $error("group bits bad");
  property p_rsv; rd && paddr == 8'h08 |-> (prdata & 32'he0f2f2f2) == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("lost flag reserved bits");
  property p_tail; rd && paddr == 8'h0c |-> prdata == 32'h0; endproperty
  a_tail: assert property (p_tail) else $error("tail bytes bad");
  property p_err; acc && paddr == 8'h28 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no error on unmapped");
  property p_ok; acc && paddr <= 8'h24 && paddr[1:0] == 2'b00 |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("error on mapped word");
  // a lost flag needs a pending one, unless the enable was just written
  property p_lost; $rose(diag_irq) |-> $past(proc_irq) || $past(acc && pwrite && paddr == 8'h1c);
  endproperty
  a_lost: assert property (p_lost) else $error("diag irq without pending");
  c_irq: cover property ($rose(diag_irq));
  c_pend: cover property ($rose(proc_irq));
  c_err: cover property (pslverr);
endmodule // cfdr_asserts

bind cfdr_top cfdr_asserts #(.ADDR_W(ADDR_W)) u_chk (.*);

//--- verification/cfdr_host.sv
// apb master standing in for the cpu that reads the record
`timescale 1ns/10ps
module cfdr_host (
  input  wire        pclk,
  input  wire        pready,
  input  wire [31:0] prdata,
  input  wire        pslverr,
  output reg         psel = 1'b0,
  output reg         penable = 1'b0,
  output reg         pwrite = 1'b0,
  output reg  [7:0]  paddr = 8'h00,
  output reg  [31:0] pwdata = 32'h0,
  output reg  [3:0]  pstrb = 4'hf
);
  // byte lanes for the following transfers; call only between transfers
  task set_strb(input [3:0] s);
    pstrb <= s;
  endtask
  // one edge first so a release and a new setup never share a time step
  task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q, output e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // cfdr_host

//--- verification/test_cfdr_top.sv
// self-checking bench for the diagnostic record block
`timescale 1ns/10ps
`include "cfdr_defines.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_cfdr_top;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg  [31:0] basic_rec = 32'h0000_13a5;
  reg  [3:0]  grp_err = 4'h0;
  reg  [14:0] ev = 15'h0;
  wire        psel, penable, pwrite, pready, pslverr, diag_irq, proc_irq;
  wire [7:0]  paddr;
  wire [31:0] pwdata, prdata;
  wire [3:0]  pstrb;
  wire [3:0]  ovf_evt = ev[3:0];
  wire [3:0]  cmp_evt = ev[7:4];
  wire        gate_open_evt = ev[8];
  wire        gate_close_evt = ev[9];
  wire        latch_evt = ev[10];
  wire [3:0]  meas_end_evt = ev[14:11];
  int         err_count = 0;
  int         n_checks = 0;
  int         pos [15] = '{2, 10, 18, 26, 3, 11, 19, 27, 24, 25, 28, 0, 8, 16, 24};
  reg  [31:0] rd;
  reg         err;
  always #5 pclk = ~pclk;
  cfdr_top dut (.*);
  cfdr_host host (.*);
  task rw(input w, input [7:0] a, input [31:0] d);
    host.xfer(w, a, d, rd, err);
  endtask
  task fire(input int i);
    @(posedge pclk);
    ev <= 15'h1 << i;
    @(posedge pclk);
    ev <= 15'h0;
  endtask
  task t_reset;
    rw(0, `CFDR_OFF_REC0, 0); `CHK("rec0", basic_rec, rd)
    rw(0, `CFDR_OFF_REC1, 0); `CHK("rec1", 32'h0004_0876, rd)
    rw(0, `CFDR_OFF_REC3, 0); `CHK("rec3", 32'h0, rd)
    rw(0, `CFDR_OFF_DEN, 0); `CHK("den", 32'h0, rd)
  endtask
  task t_header;
    basic_rec <= 32'h0000_0c5a;
    grp_err <= 4'ha;
    rw(1, `CFDR_OFF_CTRL, 32'h2);
    rw(0, `CFDR_OFF_REC1, 0); `CHK("rec1 cnt", 32'h0a04_08f6, rd)
    rw(0, `CFDR_OFF_REC0, 0); `CHK("rec0 new", basic_rec, rd)
    grp_err <= 4'h5;
    rw(1, `CFDR_OFF_CTRL, 32'h3);
    rw(0, `CFDR_OFF_REC1, 0); `CHK("rec1 frq", 32'h0504_08f6, rd)
    rw(1, `CFDR_OFF_CTRL, 32'h0);
  endtask
  // each event twice while pending: second one is lost
  task t_events;
    for (int i = 0; i < 15; i++)
    begin
      rw(1, `CFDR_OFF_CTRL, {31'h0, i > 10});
      rw(1, `CFDR_OFF_DEN, 32'h0);
      fire(i);
      fire(i);
      rw(0, `CFDR_OFF_REC2, 0); `CHK("lost", 32'h1 << pos[i], rd)
      `CHK("irqs masked", 2'b01, {diag_irq, proc_irq})
      rw(1, `CFDR_OFF_DEN, 32'hffff_ffff);
      @(posedge pclk);
      `CHK("diag irq", 1'b1, diag_irq)
      rw(1, `CFDR_OFF_DCLR, 32'hffff_ffff);
      rw(1, `CFDR_OFF_PACK, 32'hffff_ffff);
      @(posedge pclk);
      `CHK("irqs clear", 2'b00, {diag_irq, proc_irq})
    end
  endtask
  task t_refuse;
    rw(0, 8'h28, 0); `CHK("unmapped", 33'h1_0000_0000, {err, rd})
    rw(1, `CFDR_OFF_REC0, 32'hffff_ffff); `CHK("ro write", 1'b0, err)
    rw(0, `CFDR_OFF_REC0, 0); `CHK("rec0 kept", basic_rec, rd)
  endtask
  // counting flag hidden in frequency mode, then a reset in mid-run
  task t_mode_reset;
    rw(1, `CFDR_OFF_CTRL, 32'h0);
    fire(1);
    fire(1);
    rw(1, `CFDR_OFF_CTRL, 32'h1);
    rw(0, `CFDR_OFF_REC2, 0); `CHK("rec2 other mode", 32'h0, rd)
    rw(0, `CFDR_OFF_DSTAT, 0); `CHK("dstat kept", 32'h0000_0400, rd)
    rw(0, `CFDR_OFF_PPEND, 0); `CHK("ppend kept", 32'h0000_0400, rd)
    rw(0, `CFDR_OFF_CTRL, 0); `CHK("ctrl", 32'h1, rd)
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("irqs in reset", 2'b00, {diag_irq, proc_irq})
    presetn <= 1'b1;
    rw(0, `CFDR_OFF_DSTAT, 0); `CHK("dstat reset", 32'h0, rd)
    rw(0, `CFDR_OFF_PPEND, 0); `CHK("ppend reset", 32'h0, rd)
    rw(0, `CFDR_OFF_CTRL, 0); `CHK("ctrl reset", 32'h0, rd)
    rw(0, `CFDR_OFF_REC0, 0); `CHK("rec0 reset", basic_rec, rd)
  endtask
  // byte lanes: only lane 1 of the enable written, control lane 0 left alone
  task t_strobe;
    host.set_strb(4'h2);
    rw(1, `CFDR_OFF_DEN, 32'hffff_ffff);
    rw(1, `CFDR_OFF_CTRL, 32'h3);
    host.set_strb(4'hf);
    rw(0, `CFDR_OFF_DEN, 0); `CHK("den lane1", 32'h0000_ff00, rd)
    rw(0, `CFDR_OFF_CTRL, 0); `CHK("ctrl lane0 off", 32'h0, rd)
    rw(1, `CFDR_OFF_DEN, 32'h0);
  endtask
  task test_done;
    if (err_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_header;
    t_events;
    t_mode_reset;
    t_strobe;
    t_refuse;
    test_done;
  end
  initial
  begin
    #100000;
    err_count++;
    test_done;
  end
endmodule // test_cfdr_top
